// file: tde_pkg.sv
/*
 * Package for the thermal diode emulation and zero-voltage detect block.
 * Holds timing counts, state encodings and the state record of the detector.
 * Assumes a single 200 MHz system clock.
 */
package tde_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS  = 5000;
    localparam int unsigned BLANK_TIME_NS  = 100;
    localparam int unsigned DLY_TIME_NS    = 40;
    localparam int unsigned WIDTH_TIME_NS  = 50;
    localparam int unsigned REV_TIME_NS    = 20;
    // Least times round up
    localparam int unsigned BLANK_CYC = (BLANK_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned DLY_CYC   = (DLY_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned WIDTH_CYC = (WIDTH_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned REV_CYC   = (REV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned CNT_W     = 8;

    // ------------------------------------------------------------------
    // Diode emulation, power-up and detector states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        TDE_BLANK = 3'b001,
        TDE_WATCH = 3'b010,
        TDE_COND  = 3'b100
    } tde_state_e;

    typedef enum logic [2:0] {
        TDE_PWR_RAMP  = 3'b001,
        TDE_PWR_PAUSE = 3'b010,
        TDE_PWR_READY = 3'b100
    } tde_pwr_e;

    typedef struct packed {
        logic [CNT_W-1:0] rev_cnt;
        logic [CNT_W-1:0] dly_cnt;
        logic [CNT_W-1:0] wid_cnt;
        logic             dly_run;
        logic             flag;
    } tde_zvd_s;

endpackage : tde_pkg

// file: tde_zvd_if.sv
/*
 * Interface carrying the detector request and result between the top and
 * the zero-voltage detector. Assumes one clock domain.
 */
`timescale 1ns/1ps
interface tde_zvd_if;
    logic cmd_rise;
    logic vds_neg;
    logic zero_volt_flag;

    modport ctrl (output cmd_rise, output vds_neg, input zero_volt_flag);
    modport det  (input cmd_rise, input vds_neg, output zero_volt_flag);
endinterface : tde_zvd_if

// file: tde_zvd.sv
/*
 * Zero-voltage detector: counts reverse conduction time, and on a command
 * rising edge with enough of it emits a delayed fixed-width pulse.
 * Assumes inputs synchronous to i_clk_sys.
 */
`timescale 1ns/1ps
module tde_zvd
    import tde_pkg::*;
(
    input  wire logic i_clk_sys,
    input  wire logic i_rst_b,
    input  wire logic i_ce,
    tde_zvd_if.det    zif
);

    tde_zvd_s s_q;
    tde_zvd_s s_d;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // Reverse conduction run length, saturating
        if (!zif.vds_neg) begin
            s_d.rev_cnt = '0;
        end else if (s_q.rev_cnt != CNT_W'(REV_CYC)) begin
            s_d.rev_cnt = s_q.rev_cnt + CNT_W'(1);
        end
        // Pulse width first, so a pulse starting in the same cycle wins
        if (s_q.flag) begin
            s_d.wid_cnt = s_q.wid_cnt + CNT_W'(1);
            if (s_q.wid_cnt == CNT_W'(WIDTH_CYC - 1)) begin
                s_d.flag = 1'b0;
            end
        end
        // Delay run; its last cycle starts the pulse
        if (s_q.dly_run) begin
            s_d.dly_cnt = s_q.dly_cnt + CNT_W'(1);
            if (s_q.dly_cnt == CNT_W'(DLY_CYC - 1)) begin
                s_d.dly_run = 1'b0;
                s_d.flag    = 1'b1;
                s_d.wid_cnt = '0;
            end
        end
        // Short conduction or hard switching gives no pulse; a new rise restarts the delay
        if (zif.cmd_rise && zif.vds_neg && s_q.rev_cnt >= CNT_W'(REV_CYC - 1)) begin
            s_d.dly_run = 1'b1;
            s_d.dly_cnt = '0;
        end
    end

    // State register
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s_q <= '0;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    assign zif.zero_volt_flag = s_q.flag;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_zvd_start: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_ce && zif.cmd_rise && zif.vds_neg && s_q.rev_cnt >= CNT_W'(REV_CYC - 1)
        |=> s_q.dly_run && s_q.dly_cnt == CNT_W'(0))
        else $error("detected switching did not start the delay");
    chk_zvd_short: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_ce && zif.cmd_rise && s_q.rev_cnt < CNT_W'(REV_CYC - 1) && !s_q.dly_run
        |=> !s_q.dly_run)
        else $error("short reverse conduction started a pulse");
    chk_zvd_hard: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_ce && zif.cmd_rise && !zif.vds_neg && !s_q.dly_run |=> !s_q.dly_run)
        else $error("hard switching started a pulse");
    chk_zvd_end: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_ce && s_q.flag && s_q.wid_cnt == CNT_W'(WIDTH_CYC - 1)
        && !(s_q.dly_run && s_q.dly_cnt == CNT_W'(DLY_CYC - 1)) |=> !s_q.flag)
        else $error("detect pulse ran past its width");

endmodule : tde_zvd

// file: tde_top.sv
/*
 * Thermal diode emulation, zero-voltage detect and fault sequencing for a
 * power switch with integrated driver. Assumes all inputs are synchronous
 * to i_clk_sys and the comparator inputs are already filtered.
 */
`timescale 1ns/1ps

// Functional notes
// - In overtemperature shutdown, command falling edge forces blanking state, switch off, from any state
// - Blanking state waits the blank time, then moves to watch state
// - Blank time is fixed, independent of drain voltage
// - Watch state holds switch off and monitors for negative drain voltage
// - Entering overtemperature shutdown starts the machine in watch state, or in blanking if the command falls in that cycle
// - Negative drain voltage in watch state moves to conduct state
// - Conduct state turns switch on; forward current returns to watch
// - Without command edges only watch and conduct alternate
// - No lockout or counting of repeated shoot-through events
// - On command rise, check drain voltage below zero for detection
// - Detection gives one pulse of fixed width after fixed delay
// - Reverse conduction shorter than required time gives no pulse
// - Hard or partial hard switching gives no pulse
// - Fault output is low from the start of power-up
// - Supply drop pauses rail build-up until supply rises again
// - Both rails good releases fault and enables command following
// - Fault held low in either overtemperature shutdown
module tde_top
    import tde_pkg::*;
(
    input  wire logic i_clk_sys,
    input  wire logic i_rst_b,
    input  wire logic i_ce,
    input  wire logic i_cmd_in,
    input  wire logic i_vds_neg,
    input  wire logic i_fwd_current,
    input  wire logic i_overtemp_shutdown,
    input  wire logic i_driver_overtemp,
    input  wire logic i_vdd_above_rise,
    input  wire logic i_vdd_below_fall,
    input  wire logic i_aux_5v_rail_ok,
    input  wire logic i_negative_bias_rail_ok,
    output logic      o_gate_on,
    output logic      o_fault_b,
    output logic      o_rail_build_en,
    output logic      o_zero_volt_flag_out
);

    typedef struct packed {
        tde_state_e       st;
        tde_pwr_e         pwr;
        logic [CNT_W-1:0] blank_cnt;
        logic             cmd;
        logic             ot;
        logic             gate;
        logic             fault_b;
        logic             build;
        logic             flag;
    } tde_top_s;

    tde_top_s s_q;
    tde_top_s s_d;

    tde_zvd_if zif ();

    logic cmd_fall;
    logic cmd_rise;
    logic ready;

    // ------------------------------------------------------------------
    // Edge detect of command input
    // ------------------------------------------------------------------
    assign cmd_fall = s_q.cmd & ~i_cmd_in;
    assign cmd_rise = ~s_q.cmd & i_cmd_in;
    assign ready    = (s_q.pwr == TDE_PWR_READY);

    assign zif.cmd_rise = cmd_rise & ready;
    assign zif.vds_neg  = i_vds_neg;

    // Detector instance
    tde_zvd u_zvd (
        .i_clk_sys (i_clk_sys),
        .i_rst_b   (i_rst_b),
        .i_ce      (i_ce),
        .zif       (zif)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d      = s_q;
        s_d.cmd  = i_cmd_in;
        s_d.ot   = i_overtemp_shutdown;
        s_d.flag = zif.zero_volt_flag;

        // Power-up sequencing; supply glitch pauses rail build-up
        unique case (s_q.pwr)
            TDE_PWR_RAMP: begin
                if (i_vdd_below_fall) begin
                    s_d.pwr = TDE_PWR_PAUSE;
                end else if (i_aux_5v_rail_ok && i_negative_bias_rail_ok) begin
                    s_d.pwr = TDE_PWR_READY;
                end
            end
            TDE_PWR_PAUSE: begin
                if (i_vdd_above_rise) begin
                    s_d.pwr = TDE_PWR_RAMP;
                end
            end
            TDE_PWR_READY: begin
                s_d.pwr = TDE_PWR_READY;
            end
            default: begin
                s_d.pwr = TDE_PWR_RAMP;
            end
        endcase
        s_d.build = (s_d.pwr == TDE_PWR_RAMP);

        // Diode emulation; falling edge wins over everything but being out of shutdown, no lockout
        if (!i_overtemp_shutdown) begin
            s_d.st        = TDE_WATCH;
            s_d.blank_cnt = '0;
        end else if (cmd_fall) begin
            s_d.st        = TDE_BLANK;
            s_d.blank_cnt = '0;
        end else if (!s_q.ot) begin
            s_d.st = TDE_WATCH;
        end else begin
            unique case (s_q.st)
                TDE_BLANK: begin
                    // Fixed wait so a missing drain swing cannot stall us
                    s_d.blank_cnt = s_q.blank_cnt + CNT_W'(1);
                    if (s_q.blank_cnt == CNT_W'(BLANK_CYC - 1)) begin
                        s_d.st = TDE_WATCH;
                    end
                end
                TDE_WATCH: begin
                    if (i_vds_neg) begin
                        s_d.st = TDE_COND;
                    end
                end
                TDE_COND: begin
                    if (i_fwd_current) begin
                        s_d.st = TDE_WATCH;
                    end
                end
                default: begin
                    s_d.st = TDE_BLANK;
                end
            endcase
        end

        // Gate: off until ready; in shutdown only conduct state turns on; off in driver overtemp; else follow command
        if (!ready) begin
            s_d.gate = 1'b0;
        end else if (i_overtemp_shutdown) begin
            s_d.gate = (s_d.st == TDE_COND);
        end else if (i_driver_overtemp) begin
            s_d.gate = 1'b0;
        end else begin
            s_d.gate = i_cmd_in;
        end

        // Fault low until ready and during either shutdown
        s_d.fault_b = ready & ~i_overtemp_shutdown & ~i_driver_overtemp;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s_q.st        <= TDE_WATCH;
            s_q.pwr       <= TDE_PWR_RAMP;
            s_q.blank_cnt <= '0;
            s_q.cmd       <= 1'b0;
            s_q.ot        <= 1'b0;
            s_q.gate      <= 1'b0;
            s_q.fault_b   <= 1'b0;
            s_q.build     <= 1'b0;
            s_q.flag      <= 1'b0;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    assign o_gate_on            = s_q.gate;
    assign o_fault_b            = s_q.fault_b;
    assign o_rail_build_en      = s_q.build;
    assign o_zero_volt_flag_out = s_q.flag;

    // ------------------------------------------------------------------
    // Checks: diode emulation state machine
    // ------------------------------------------------------------------
    // In shutdown a falling command edge restarts blanking with the switch off
    chk_fall_blank: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_ce && i_overtemp_shutdown && cmd_fall |=> s_q.st == TDE_BLANK)
        else $error("falling edge did not force blanking");

    chk_fall_restart: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_ce && i_overtemp_shutdown && cmd_fall
        |=> s_q.blank_cnt == CNT_W'(0) && !o_gate_on)
        else $error("falling edge did not restart blanking");

    // Blanking is a fixed count, so no drain condition can stall it
    chk_blank_len: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        s_q.st == TDE_BLANK && s_q.blank_cnt == CNT_W'(BLANK_CYC - 1) && i_ce
        && i_overtemp_shutdown && !cmd_fall |=> s_q.st == TDE_WATCH)
        else $error("blanking did not end on time");

    chk_blank_stay: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_ce && s_q.ot && i_overtemp_shutdown && s_q.st == TDE_BLANK && !cmd_fall
        && s_q.blank_cnt != CNT_W'(BLANK_CYC - 1) |=> s_q.st == TDE_BLANK)
        else $error("blanking ended early");

    chk_blank_fixed: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        s_q.st == TDE_BLANK && s_q.ot |-> s_q.blank_cnt < CNT_W'(BLANK_CYC))
        else $error("blank counter ran past its limit");

    // In shutdown the switch is on only in the conduct state
    chk_off_watch: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        s_q.ot && s_q.st != TDE_COND && $past(i_overtemp_shutdown) && $past(i_ce)
        |-> !o_gate_on)
        else $error("switch on outside conduct state");

    chk_gate_state: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        s_q.ot && $past(i_ce) && $past(ready) |-> o_gate_on == (s_q.st == TDE_COND))
        else $error("gate does not match diode state");

    // Plain ideal diode: watch and conduct alternate on the comparators
    chk_ot_entry: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_ce && i_overtemp_shutdown && !s_q.ot && !cmd_fall |=> s_q.st == TDE_WATCH)
        else $error("shutdown entry not in watch state");

    chk_neg_cond: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_ce && s_q.ot && i_overtemp_shutdown && s_q.st == TDE_WATCH && i_vds_neg
        && !cmd_fall |=> s_q.st == TDE_COND)
        else $error("negative drain did not start conduction");

    chk_watch_stay: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_ce && s_q.ot && i_overtemp_shutdown && s_q.st == TDE_WATCH && !i_vds_neg
        && !cmd_fall |=> s_q.st == TDE_WATCH)
        else $error("watch state left without negative drain");

    chk_fwd_back: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_ce && s_q.ot && i_overtemp_shutdown && s_q.st == TDE_COND && i_fwd_current
        && !cmd_fall |=> s_q.st == TDE_WATCH)
        else $error("forward current did not leave conduction");

    chk_cond_stay: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_ce && s_q.ot && i_overtemp_shutdown && s_q.st == TDE_COND && !i_fwd_current
        && !cmd_fall |=> s_q.st == TDE_COND)
        else $error("conduction left without forward current");

    // ------------------------------------------------------------------
    // Checks: power-up sequencing, fault and gate outputs
    // ------------------------------------------------------------------
    chk_fault_low: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_ce && (i_overtemp_shutdown || i_driver_overtemp || !ready) |=> !o_fault_b)
        else $error("fault released during shutdown or power-up");

    chk_pause_enter: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_ce && s_q.pwr == TDE_PWR_RAMP && i_vdd_below_fall
        |=> s_q.pwr == TDE_PWR_PAUSE && !o_rail_build_en)
        else $error("supply drop did not pause rail build-up");

    chk_pause_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_ce && s_q.pwr == TDE_PWR_PAUSE && !i_vdd_above_rise
        |=> s_q.pwr == TDE_PWR_PAUSE && !o_rail_build_en)
        else $error("rail build-up resumed without supply");

    chk_ready_rails: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_ce && s_q.pwr == TDE_PWR_RAMP && !i_vdd_below_fall
        && !(i_aux_5v_rail_ok && i_negative_bias_rail_ok) |=> s_q.pwr == TDE_PWR_RAMP)
        else $error("ready reached before both rails");

    chk_ready_stay: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        s_q.pwr == TDE_PWR_READY |=> s_q.pwr == TDE_PWR_READY)
        else $error("ready state was left");

    chk_gate_unready: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_ce && !ready |=> !o_gate_on)
        else $error("switch on before power-up finished");

    chk_gate_follow: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_ce && ready && !i_overtemp_shutdown && !i_driver_overtemp
        |=> o_gate_on == $past(i_cmd_in))
        else $error("gate did not follow command");

    chk_drv_ot_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_ce && !i_overtemp_shutdown && i_driver_overtemp |=> !o_gate_on)
        else $error("switch on during driver overtemperature");

    // Detector output stands for more than one cycle
    chk_flag_width: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        $rose(o_zero_volt_flag_out) && i_ce |=> o_zero_volt_flag_out)
        else $error("detect pulse too short");

    // A low enable must freeze every register, outputs included
    chk_ce_freeze: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        !i_ce |=> $stable(s_q))
        else $error("state moved while the clock enable was low");

endmodule : tde_top

// file: tde_ctrl_model.sv
/*
 * Behavioural model of the converter controller that drives the switch
 * command. Assumes the bench calls its tasks from one process only.
 */
`timescale 1ns/1ps
module tde_ctrl_model (
    input  wire logic i_clk_sys,
    output logic      o_cmd
);
    // ------------------------------------------------------------------
    // Command driver
    // ------------------------------------------------------------------
    // Switch off by default so nothing conducts before the bench acts
    initial o_cmd = 1'b0;

    // Change the command just after an edge, never on it
    task automatic drive_cmd(input logic v);
        @(posedge i_clk_sys);
        #1 o_cmd = v;
    endtask

    // Toggle before switching so a device in shutdown passes blanking
    task automatic toggle_first();
        drive_cmd(1'b1);
        drive_cmd(1'b0);
    endtask
endmodule // tde_ctrl_model

// file: tde_top_tb.sv
/*
 * Self-checking bench for the diode emulation and zero-voltage detect top.
 * Assumes the timing counts of tde_pkg and a 200 MHz clock.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s expected %0d seen %0d", nm, e, g); end end
module tde_top_tb;
    import tde_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_rst_b   = 1'b0;
    logic vds_neg = 1'b0, fwd = 1'b0, ot = 1'b0, drv_ot = 1'b0;
    logic v_rise = 1'b0, v_fall = 1'b0, r5 = 1'b0, rneg = 1'b0;
    logic ce = 1'b1;
    logic cmd, gate, fault_b, build, zflag;
    int   fail_count = 0;
    int   samples_checked = 0;

    always #2.5 i_clk_sys = ~i_clk_sys;

    tde_ctrl_model u_ctl (.i_clk_sys(i_clk_sys), .o_cmd(cmd));
    tde_top u_dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(ce),
        .i_cmd_in(cmd), .i_vds_neg(vds_neg), .i_fwd_current(fwd),
        .i_overtemp_shutdown(ot), .i_driver_overtemp(drv_ot),
        .i_vdd_above_rise(v_rise), .i_vdd_below_fall(v_fall),
        .i_aux_5v_rail_ok(r5), .i_negative_bias_rail_ok(rneg), .o_gate_on(gate),
        .o_fault_b(fault_b), .o_rail_build_en(build), .o_zero_volt_flag_out(zflag));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Inputs move 1 ns after an edge so the sampling edge never races
    task automatic step(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask

    // Supply glitch pauses build-up, rails good releases the fault
    task automatic t_power();
        step(2);
        `CHK("fault_rst", 1'b0, fault_b)
        `CHK("build_ramp", 1'b1, build)
        v_fall = 1'b1;
        step(2);
        `CHK("build_pause", 1'b0, build)
        `CHK("fault_pause", 1'b0, fault_b)
        v_fall = 1'b0;
        v_rise = 1'b1;
        step(2);
        `CHK("build_resume", 1'b1, build)
        r5 = 1'b1;
        step(3);
        `CHK("fault_one_rail", 1'b0, fault_b)
        rneg = 1'b1;
        step(3);
        `CHK("fault_ready", 1'b1, fault_b)
        u_ctl.drive_cmd(1'b1);
        step(2);
        `CHK("gate_follow", 1'b1, gate)
        drv_ot = 1'b1;
        step(2);
        `CHK("fault_drv_ot", 1'b0, fault_b)
        drv_ot = 1'b0;
        step(2);
        `CHK("fault_clear", 1'b1, fault_b)
    endtask

    // Low enable freezes the gate; it catches up once enable returns
    task automatic t_freeze();
        ce = 1'b0;
        u_ctl.drive_cmd(1'b0);
        step(3);
        `CHK("gate_frozen", 1'b1, gate)
        ce = 1'b1;
        step(2);
        `CHK("gate_thawed", 1'b0, gate)
    endtask

    // Shutdown: diode cycling, then blanking on every command fall
    task automatic t_shutdown();
        ot = 1'b1;
        step(3);
        `CHK("gate_watch", 1'b0, gate)
        `CHK("fault_ot", 1'b0, fault_b)
        repeat (2) begin
            vds_neg = 1'b1;
            step(3);
            `CHK("gate_cond", 1'b1, gate)
            vds_neg = 1'b0;
            fwd = 1'b1;
            step(3);
            `CHK("gate_fwd", 1'b0, gate)
            fwd = 1'b0;
        end
        vds_neg = 1'b1;
        repeat (2) begin
            u_ctl.toggle_first();
            step(3);
            `CHK("gate_blank", 1'b0, gate)
            step(BLANK_CYC - 4);
            `CHK("gate_blank_end", 1'b0, gate)
            step(5);
            `CHK("gate_after_blank", 1'b1, gate)
        end
        vds_neg = 1'b0;
        ot = 1'b0;
        step(3);
    endtask

    // One command rise; the drain sits below zero for rev + 3 samples, rise included, and never when rev is 0
    task automatic t_zvd(input int rev, input logic expect_pulse);
        int n;
        int w;
        n = 0;
        w = 0;
        u_ctl.drive_cmd(1'b0);
        step(3);
        vds_neg = (rev > 0);
        step(rev);
        u_ctl.drive_cmd(1'b1);
        step(2);
        vds_neg = 1'b0;
        while (zflag !== 1'b1 && n < DLY_CYC + WIDTH_CYC + 8) begin
            step(1);
            n++;
        end
        if (expect_pulse) begin
            // n starts one edge after the rise; delay run plus output flop
            `CHK("zvd_delay", DLY_CYC, n)
            while (zflag === 1'b1 && w < 40) begin
                step(1);
                w++;
            end
            `CHK("zvd_width", WIDTH_CYC, w)
        end else begin
            `CHK("zvd_none", 1'b0, zflag)
        end
    endtask

    // ------------------------------------------------------------------
    // Verdict
    // ------------------------------------------------------------------
    task automatic give_verdict();
        if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge i_clk_sys);
        #1 i_rst_b = 1'b1;
        t_power();
        t_freeze();
        t_shutdown();
        t_zvd(REV_CYC + 1, 1'b1);
        t_zvd(REV_CYC - 3, 1'b0);
        t_zvd(0, 1'b0);
        t_zvd(REV_CYC - 2, 1'b1);
        give_verdict();
    end

    // Watchdog: the whole run needs well under 2000 cycles
    initial begin
        #(5 * 20000);
        fail_count++;
        give_verdict();
    end
endmodule // tde_top_tb
